// File: design/csw_pkg.sv
// package: register map, field layout, reset values and states of the compare-swap block
package csw_pkg;
	// register byte offsets on the wishbone bus
	localparam logic [7:0] CSW_OFF_DATA = 8'h0C; // swap data word
	localparam logic [7:0] CSW_OFF_CMP = 8'h10; // compare word
	localparam logic [7:0] CSW_OFF_CTL = 8'h14; // swap control word
	localparam logic [7:0] CSW_OFF_ROM = 8'h18; // rom header quadlet
	localparam logic [7:0] CSW_OFF_IDENT = 8'h1C; // bus ident quadlet
	localparam logic [7:0] CSW_OFF_IRQ_STAT = 8'h40; // sticky event bits
	localparam logic [7:0] CSW_OFF_IRQ_MASK = 8'h44; // interrupt mask
	// swap control word fields
	localparam int CSW_CTL_DONE_BIT = 31; // completion flag position
	localparam int CSW_CTL_SEL_LSB = 0; // resource select low bit
	localparam int CSW_CTL_SEL_W = 2; // resource select width
	// rom header fields
	localparam int CSW_ROM_INFO_LSB = 24; // info length, 8 bits
	localparam int CSW_ROM_CRCLEN_LSB = 16; // crc coverage length, 8 bits
	localparam int CSW_ROM_CHECK_LSB = 0; // rom check value, 16 bits
	// interrupt status layout
	localparam int CSW_IRQ_DONE_BIT = 0; // compare-swap finished event
	// values after reset
	localparam logic CSW_DONE_RST = 1'b1; // flag reads one out of reset
	localparam logic [1:0] CSW_SEL_RST = 2'h0; // bus manager id selected
	localparam logic [31:0] CSW_ROM_RST = 32'h00000000; // check value zeroed too
	localparam logic [31:0] CSW_WORD_RST = 32'h00000000; // data and compare words
	localparam logic [31:0] CSW_RES_RST = 32'h00000000; // plain default for resources
	// fixed ascii "1394" identification quadlet
	localparam logic [31:0] CSW_BUS_IDENT = 32'h31333934;
	// bus-side address where the rom header appears
	localparam logic [47:0] CSW_CFG_ROM_ADDR = 48'hFFFFF0000400;
	// resource indices
	localparam logic [1:0] CSW_RES_BM_ID = 2'h0; // bus manager id
	localparam logic [1:0] CSW_RES_BW_AVAIL = 2'h1; // bandwidth available
	localparam logic [1:0] CSW_RES_CH_HI = 2'h2; // channels available high
	localparam logic [1:0] CSW_RES_CH_LO = 2'h3; // channels available low
	// compare-swap engine states
	typedef enum logic [0:0] {CSW_ST_IDLE, CSW_ST_CMP} csw_state_t;
endpackage

// File: design/csw_res_bank.sv
// the four bus-management resource words, one write port, all read in parallel
module csw_res_bank
	import csw_pkg::*;
#(
	parameter int N = 4
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [1:0] wr_idx_i,
	input wire logic [31:0] wr_data_i,
	output logic [N-1:0][31:0] rd_val_o
);
	// the two-bit select can reach exactly four words
	if (N != 4)
	begin : g_chk
		$error("csw_res_bank needs N == 4");
	end
	////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < N; i++)
	begin : g_word
		logic [31:0] word_d; // next value
		logic [31:0] word_q; // stored resource
		// write only the addressed word
		always_comb
		begin
			word_d = word_q;
			if (wr_en_i && (wr_idx_i == 2'(i)))
			begin
				word_d = wr_data_i;
			end
		end
		// register
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				word_q <= CSW_RES_RST;
			end
			else
			begin
				word_q <= word_d;
			end
		end
		assign rd_val_o[i] = word_q;
	end
endmodule

// File: design/csw_swap_engine.sv
// one-cycle compare-and-swap against the selected resource word
module csw_swap_engine
	import csw_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [1:0] sel_i,
	input wire logic [31:0] cmp_i,
	input wire logic [31:0] swap_i,
	input wire logic [3:0][31:0] res_i,
	output logic res_wr_o,
	output logic [1:0] res_idx_o,
	output logic [31:0] res_data_o,
	output logic done_o,
	output logic [31:0] old_o
);
	csw_state_t state_d; // next state
	csw_state_t state_q; // current state
	logic [1:0] idx_d; // latched select
	logic [1:0] idx_q;
	////////////////////////////////////////////////////////////////////////
	// next state; a start while busy cannot happen, the bus needs two cycles
	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		case (state_q)
			CSW_ST_IDLE:
			begin
				if (start_i)
				begin
					state_d = CSW_ST_CMP;
					idx_d = sel_i;
				end
			end
			CSW_ST_CMP:
			begin
				state_d = CSW_ST_IDLE;
			end
			default:
			begin
				state_d = CSW_ST_IDLE;
			end
		endcase
	end
	// register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= CSW_ST_IDLE;
			idx_q <= CSW_RES_BM_ID;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// store swap data only on equality, always report the prior value
	assign done_o = (state_q == CSW_ST_CMP);
	assign old_o = res_i[idx_q];
	assign res_idx_o = idx_q;
	assign res_data_o = swap_i;
	assign res_wr_o = done_o && (res_i[idx_q] == cmp_i);
endmodule

// File: design/csw_top.sv
// top: wishbone register bank for compare-swap, rom header and bus ident
module csw_top
	import csw_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic [31:0] rom_header_o,
	output logic [31:0] bus_ident_o
);
	////////////////////////////////////////////////////////////////////////
	// byte-lane merge, shared by the swap data, compare and rom header words
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
			begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	logic req; // new access, taken this edge
	logic wr_data; // write strobes per register
	logic wr_cmp;
	logic wr_ctl;
	logic wr_rom;
	logic wr_stat;
	logic wr_mask;
	logic eng_done; // engine finished this cycle
	logic [31:0] eng_old; // prior resource value
	logic res_wr; // resource write strobe
	logic [1:0] res_idx;
	logic [31:0] res_wdata;
	logic [3:0][31:0] res_val; // all resource words
	logic [31:0] ctl_rd; // assembled control read value
	logic [31:0] rd_mux; // read data before the flop
	// register state
	logic ack_d, ack_q;
	logic [31:0] dat_d, dat_q;
	logic [31:0] data_d, data_q; // swap data word
	logic [31:0] cmp_d, cmp_q; // compare word
	logic done_d, done_q; // completion flag
	logic [1:0] sel_d, sel_q; // resource select
	logic [31:0] rom_d, rom_q; // rom header
	logic stat_d, stat_q; // sticky done event
	logic mask_d, mask_q; // event mask
	logic irq_d, irq_q;
	logic [31:0] ident_d, ident_q; // constant kept in a flop so the output is registered
	////////////////////////////////////////////////////////////////////////
	// decode: a request is taken once, the cycle before ack
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_data = req && wb_we_i && (wb_adr_i == CSW_OFF_DATA);
	assign wr_cmp = req && wb_we_i && (wb_adr_i == CSW_OFF_CMP);
	assign wr_ctl = req && wb_we_i && (wb_adr_i == CSW_OFF_CTL);
	assign wr_rom = req && wb_we_i && (wb_adr_i == CSW_OFF_ROM);
	assign wr_stat = req && wb_we_i && (wb_adr_i == CSW_OFF_IRQ_STAT);
	assign wr_mask = req && wb_we_i && (wb_adr_i == CSW_OFF_IRQ_MASK);
	// reserved control bits are simply never stored
	always_comb
	begin
		ctl_rd = 32'h00000000;
		ctl_rd[CSW_CTL_DONE_BIT] = done_q;
		ctl_rd[CSW_CTL_SEL_LSB +: CSW_CTL_SEL_W] = sel_q;
	end
	// read mux; unmapped offsets answer zero
	always_comb
	begin
		case (wb_adr_i)
			CSW_OFF_DATA: rd_mux = data_q;
			CSW_OFF_CMP: rd_mux = cmp_q;
			CSW_OFF_CTL: rd_mux = ctl_rd;
			CSW_OFF_ROM: rd_mux = rom_q;
			CSW_OFF_IDENT: rd_mux = CSW_BUS_IDENT;
			CSW_OFF_IRQ_STAT: rd_mux = {31'h00000000, stat_q};
			CSW_OFF_IRQ_MASK: rd_mux = {31'h00000000, mask_q};
			default: rd_mux = 32'h00000000;
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	// next values of the bus side and the software registers
	always_comb
	begin
		ack_d = req;
		dat_d = dat_q;
		if (req && !wb_we_i)
		begin
			dat_d = rd_mux;
		end
		// engine's prior value wins; bus cannot write in that cycle anyway
		data_d = data_q;
		if (eng_done)
		begin
			data_d = eng_old;
		end
		else if (wr_data)
		begin
			data_d = merge_bytes(data_q, wb_dat_i, wb_sel_i);
		end
		cmp_d = wr_cmp ? merge_bytes(cmp_q, wb_dat_i, wb_sel_i) : cmp_q;
		// set wins over the clear of a same-cycle write
		done_d = done_q;
		if (eng_done)
		begin
			done_d = 1'b1;
		end
		else if (wr_ctl)
		begin
			done_d = 1'b0;
		end
		sel_d = sel_q;
		if (wr_ctl && wb_sel_i[0])
		begin
			sel_d = wb_dat_i[CSW_CTL_SEL_LSB +: CSW_CTL_SEL_W];
		end
		// all three header fields are plain byte-writable storage
		rom_d = wr_rom ? merge_bytes(rom_q, wb_dat_i, wb_sel_i) : rom_q;
		// sticky event: write one to clear, a new event still wins
		stat_d = stat_q;
		if (wr_stat && wb_sel_i[0] && wb_dat_i[CSW_IRQ_DONE_BIT])
		begin
			stat_d = 1'b0;
		end
		if (eng_done)
		begin
			stat_d = 1'b1;
		end
		mask_d = mask_q;
		if (wr_mask && wb_sel_i[0])
		begin
			mask_d = wb_dat_i[CSW_IRQ_DONE_BIT];
		end
		irq_d = stat_d && mask_d;
		// ident never takes a write, it only reloads its constant
		ident_d = CSW_BUS_IDENT;
	end
	// register everything
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
			data_q <= CSW_WORD_RST;
			cmp_q <= CSW_WORD_RST;
			done_q <= CSW_DONE_RST;
			sel_q <= CSW_SEL_RST;
			rom_q <= CSW_ROM_RST;
			stat_q <= 1'b0;
			mask_q <= 1'b0;
			irq_q <= 1'b0;
			ident_q <= CSW_BUS_IDENT;
		end
		else
		begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			data_q <= data_d;
			cmp_q <= cmp_d;
			done_q <= done_d;
			sel_q <= sel_d;
			rom_q <= rom_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			ident_q <= ident_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops; ident is a constant register
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign irq_o = irq_q;
	assign rom_header_o = rom_q;
	assign bus_ident_o = ident_q;
	////////////////////////////////////////////////////////////////////////
	// any control write starts the operation; the select it carries applies only when byte lane 0 is enabled
	csw_swap_engine u_engine (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(wr_ctl),
		.sel_i(sel_d),
		.cmp_i(cmp_q),
		.swap_i(data_q),
		.res_i(res_val),
		.res_wr_o(res_wr),
		.res_idx_o(res_idx),
		.res_data_o(res_wdata),
		.done_o(eng_done),
		.old_o(eng_old)
	);
	// resource words, only reached through the engine
	csw_res_bank #(
		.N(4)
	) u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_en_i(res_wr),
		.wr_idx_i(res_idx),
		.wr_data_i(res_wdata),
		.rd_val_o(res_val)
	);
	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// bus side and control word
	AST_CTL_RSVD_ZERO: assert property (
		(req && !wb_we_i && wb_adr_i == CSW_OFF_CTL) |=> (wb_dat_o[30:2] == 29'h0))
		else $error("reserved control bits read nonzero");
	AST_DONE_CLEAR: assert property (
		wr_ctl |=> !done_q)
		else $error("completion flag not cleared by control write");
	AST_DONE_SET: assert property (
		wr_ctl |=> ##1 done_q)
		else $error("completion flag not set after operation");
	AST_SEL_WRITE: assert property (
		(wr_ctl && wb_sel_i[0]) |=> (sel_q == $past(wb_dat_i[1:0])))
		else $error("resource select not stored");
	AST_SWAP_ON_EQUAL: assert property (
		(eng_done && res_val[res_idx] == cmp_q)
		|=> (res_val[$past(res_idx)] == $past(data_q)))
		else $error("swap data not stored on equal compare");
	AST_KEEP_ON_DIFF: assert property (
		(eng_done && res_val[res_idx] != cmp_q) |=> $stable(res_val))
		else $error("resource changed on failed compare");
	AST_DATA_OLD: assert property (
		eng_done |=> (data_q == $past(eng_old)))
		else $error("prior resource value not returned");
	AST_BUS_IDENT: assert property (
		(req && !wb_we_i && wb_adr_i == CSW_OFF_IDENT) |=> (wb_dat_o == 32'h31333934))
		else $error("bus ident constant wrong");
	AST_ROM_WRITE: assert property (
		(wr_rom && wb_sel_i == 4'hF) |=> (rom_header_o == $past(wb_dat_i)))
		else $error("rom header write lost");
	AST_IRQ_RAISE: assert property (
		(eng_done && mask_q && !wr_mask) |=> irq_o)
		else $error("interrupt not raised");
	AST_ACK_ONCE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	// software can never raise the flag, only the engine does
	AST_DONE_HOLD: assert property (
		(!done_q && !eng_done) |=> !done_q)
		else $error("completion flag rose without an operation");
	AST_CTL_DONE_READ: assert property (
		(req && !wb_we_i && wb_adr_i == CSW_OFF_CTL) |=> (wb_dat_o[31] == $past(done_q)))
		else $error("control read lost the completion flag");
	// the select only moves on a control write that enables its byte lane
	AST_SEL_HOLD: assert property (
		!(wr_ctl && wb_sel_i[0]) |=> $stable(sel_q))
		else $error("resource select changed without a write");
	AST_DATA_WRITE: assert property (
		(wr_data && wb_sel_i == 4'hF) |=> (data_q == $past(wb_dat_i)))
		else $error("swap data word write lost");
	AST_CMP_WRITE: assert property (
		(wr_cmp && wb_sel_i == 4'hF) |=> (cmp_q == $past(wb_dat_i)))
		else $error("compare word write lost");
	// header holds its value between writes; the bus side relies on it
	AST_ROM_KEEP: assert property (
		!wr_rom |=> $stable(rom_q))
		else $error("rom header changed without a write");
	AST_IDENT_CONST: assert property (
		bus_ident_o == 32'h31333934)
		else $error("bus ident output not constant");
	// every access answered one cycle after it is taken
	AST_ACK_ANSWER: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("access not acknowledged");
	// interrupt side
	AST_STAT_CLEAR: assert property (
		(wr_stat && wb_sel_i[0] && wb_dat_i[CSW_IRQ_DONE_BIT] && !eng_done) |=> !stat_q)
		else $error("event bit not cleared by write of one");
	AST_IRQ_MASKED: assert property (
		!mask_q |-> !irq_o)
		else $error("interrupt raised while masked");
	// main scenarios reached
	COV_SWAP_HIT: cover property (eng_done && res_val[res_idx] == cmp_q);
	COV_SWAP_MISS: cover property (eng_done && res_val[res_idx] != cmp_q);
	COV_IRQ: cover property (irq_o ##1 wr_stat);
	COV_CTL_READ: cover property (req && !wb_we_i && wb_adr_i == CSW_OFF_CTL && done_q);
	COV_ROM_LANE: cover property (wr_rom && wb_sel_i != 4'hF);
endmodule

// File: bench/csw_top_test.sv
// self-checking testbench for the compare-swap, rom header and bus ident register block
module swap_compare_word_swap_and_rom_header_test;
	timeunit 1ns;
	timeprecision 1ps;
	import csw_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	logic clk_i = 1'b0; // 250 MHz system clock
	logic rst_i = 1'b1; // sync reset, held at start
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	logic [31:0] rom_header_o;
	logic [31:0] bus_ident_o;
	logic [31:0] rd; // last read data
	int mismatches = 0;
	int samples_checked = 0;
	////////////////////////////////////////////////////////////////////////////////
	csw_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.rom_header_o(rom_header_o), .bus_ident_o(bus_ident_o));
	// half period of 2 ns
	always #2 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run, shared with the watchdog
	task automatic complete_run();
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one comparison, four-state exact
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// classic single wishbone cycle; ack and read data both taken at the rising edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel, output logic [31:0] data);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		// no latency assumed; a lost ack is left to the watchdog
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
		begin
			@(posedge clk_i);
		end
		data = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reset values as seen by software
	task automatic t_reset();
		bus(1'b0, CSW_OFF_CTL, 32'h00000000, 4'hF, rd);
		check(rd, 32'h80000000);
		bus(1'b0, CSW_OFF_ROM, 32'h00000000, 4'hF, rd);
		check({rd[31:16], 16'h0000}, 32'h00000000);
		check(rom_header_o, 32'h00000000);
		bus(1'b0, CSW_OFF_IDENT, 32'h00000000, 4'hF, rd);
		check(rd, 32'h31333934);
	endtask
	// one swap: load words, start with reserved bits set, then read back
	task automatic do_swap(input logic [1:0] s, input logic [31:0] cmp,
		input logic [31:0] swp, input logic [31:0] prior);
		bus(1'b1, CSW_OFF_DATA, swp, 4'hF, rd);
		bus(1'b1, CSW_OFF_CMP, cmp, 4'hF, rd);
		// reserved ones must not stick
		bus(1'b1, CSW_OFF_CTL, {30'h1FFFFFFF, s}, 4'hF, rd);
		bus(1'b0, CSW_OFF_CTL, 32'h00000000, 4'hF, rd);
		check(rd, {1'b1, 29'h00000000, s});
		bus(1'b0, CSW_OFF_DATA, 32'h00000000, 4'hF, rd);
		check(rd, prior);
	endtask
	// every select: store, failed compare, good compare; leaves resource at b
	task automatic t_swaps();
		logic [31:0] a;
		logic [31:0] b;
		for (int i = 0; i < 4; i++)
		begin
			a = 32'hA5000000 | 32'(i);
			b = 32'h5A00F000 | 32'(i);
			// prior zero also proves earlier selects left this word alone
			do_swap(2'(i), 32'h00000000, a, 32'h00000000);
			do_swap(2'(i), b, b, a);
			do_swap(2'(i), a, b, a);
			do_swap(2'(i), b, b, b);
		end
	endtask
	// rom header fields with byte lanes, mirror output
	task automatic t_rom();
		// host loads every header field before anything relies on it
		bus(1'b1, CSW_OFF_ROM, 32'h12345678, 4'hF, rd);
		bus(1'b1, CSW_OFF_ROM, 32'hFFFFFFFF, 4'h4, rd);
		bus(1'b0, CSW_OFF_ROM, 32'h00000000, 4'hF, rd);
		check(rd, 32'h12FF5678);
		check(rom_header_o, 32'h12FF5678);
		bus(1'b1, CSW_OFF_ROM, 32'hFFFFFFFF, 4'h8, rd);
		bus(1'b0, CSW_OFF_ROM, 32'h00000000, 4'hF, rd);
		check(rd, 32'hFFFF5678);
	endtask
	// read-only ident and an unmapped place
	task automatic t_readonly();
		bus(1'b1, CSW_OFF_IDENT, 32'h00000000, 4'hF, rd);
		bus(1'b0, CSW_OFF_IDENT, 32'h00000000, 4'hF, rd);
		check(rd, 32'h31333934);
		check(bus_ident_o, 32'h31333934);
		bus(1'b1, 8'h80, 32'hFFFFFFFF, 4'hF, rd);
		bus(1'b0, 8'h80, 32'h00000000, 4'hF, rd);
		check(rd, 32'h00000000);
	endtask
	// masked event, unmask, clear, then a fresh completion raises the line
	task automatic t_irq();
		check(32'(irq_o), 32'h00000000);
		bus(1'b0, CSW_OFF_IRQ_STAT, 32'h00000000, 4'hF, rd);
		check(rd, 32'h00000001);
		bus(1'b1, CSW_OFF_IRQ_MASK, 32'h00000001, 4'hF, rd);
		bus(1'b0, CSW_OFF_IRQ_MASK, 32'h00000000, 4'hF, rd);
		check(rd, 32'h00000001);
		check(32'(irq_o), 32'h00000001);
		bus(1'b1, CSW_OFF_IRQ_STAT, 32'h00000001, 4'hF, rd);
		bus(1'b0, CSW_OFF_IRQ_STAT, 32'h00000000, 4'hF, rd);
		check(rd, 32'h00000000);
		check(32'(irq_o), 32'h00000000);
		do_swap(2'h1, 32'h00000000, 32'h00000000, 32'h5A00F001);
		check(32'(irq_o), 32'h00000001);
	endtask
	// byte lanes on the compare word, and a control write that skips the select lane
	task automatic t_lanes();
		bus(1'b1, CSW_OFF_CMP, 32'hFFFFFFFF, 4'h1, rd);
		bus(1'b0, CSW_OFF_CMP, 32'h00000000, 4'hF, rd);
		check(rd, 32'h000000FF);
		bus(1'b1, CSW_OFF_CTL, 32'h00000003, 4'h0, rd);
		bus(1'b0, CSW_OFF_CTL, 32'h00000000, 4'hF, rd);
		check(rd, 32'h80000001);
		bus(1'b0, CSW_OFF_DATA, 32'h00000000, 4'hF, rd);
		check(rd, 32'h5A00F001);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		check(32'(wb_ack_o), 32'h00000000);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_swaps();
		t_rom();
		t_readonly();
		t_irq();
		t_lanes();
		complete_run();
	end
	// watchdog: run needs a few hundred cycles at most
	initial
	begin
		#40000;
		mismatches++;
		complete_run();
	end
endmodule
